// file: logic/xiocd_map.svh
`ifndef XIOCD_MAP_SVH
`define XIOCD_MAP_SVH
`define XIOCD_SMK      16'h2000
`define XIOCD_CLIR     16'h2001
`define XIOCD_ENBL     16'h2002
`define XIOCD_DSBL     16'h2003
`define XIOCD_RPI      16'h2004
`define XIOCD_SPI      16'h2005
`define XIOCD_SET_FAULT_MASK_CMD     16'h2006
`define XIOCD_OD       16'h2008
`define XIOCD_RNS      16'h200a
`define XIOCD_WPBSA    16'h200c
`define XIOCD_WSW      16'h200e
`define XIOCD_WPBSB    16'h200f
`define XIOCD_CO       16'h4000
`define XIOCD_NOP_OUT  16'h4001
`define XIOCD_LOAD_TIMER1_RELOAD_CMD     16'h4002
`define XIOCD_MPEN     16'h4003
`define XIOCD_ESUR     16'h4004
`define XIOCD_DSUR     16'h4005
`define XIOCD_DMAON    16'h4006
`define XIOCD_DMAOFF   16'h4007
`define XIOCD_LOAD_TIMER2_RELOAD_CMD     16'h400f
`define XIOCD_RFR      16'h8401
`define XIOCD_CC       16'h8402
`define XIOCD_READ_FAIL_ADDRESS_CMD     16'h8407
`define XIOCD_READ_FAIL_PAGE_CMD     16'h8408
`define XIOCD_ICW      16'h840c
`define XIOCD_RCW      16'h8410
`define XIOCD_RMK      16'ha000
`define XIOCD_RPIR     16'ha004
`define XIOCD_READ_FAULT_MASK_CMD     16'ha006
`define XIOCD_READ_DISCRETE_OUT_CMD     16'ha008
`define XIOCD_READ_BANK_SELECT_CMD     16'ha00c
`define XIOCD_RSW      16'ha00e
`define XIOCD_READ_CLEAR_FAULT_CMD     16'ha00f
`define XIOCD_CI       16'hc000
`define XIOCD_NOP_IN   16'hc001
`define XIOCD_ITAR     16'hc002
`define XIOCD_ITBR     16'hc00f
`define XIOCD_HI_BPU_W 8'h50
`define XIOCD_HI_BPU_R 8'hd0
`define XIOCD_HI_IPW   8'h51
`define XIOCD_HI_OPW   8'h52
`define XIOCD_HI_IPR   8'hd1
`define XIOCD_HI_OPR   8'hd2
`define XIOCD_CFG_BPU  2
`define XIOCD_CFG_MMU  1
`define XIOCD_CFG_DMA  0
`define XIOCD_CFG_CON  3
`endif

// file: logic/xiocd_pkg.sv
package xiocd_pkg;
    typedef enum logic [1:0] {XIOCD_NONE, XIOCD_INT, XIOCD_EXT, XIOCD_ILL} xiocd_kind_e;
    typedef struct packed {
        logic        valid;
        logic [15:0] code;
        logic [15:0] wdata;
    } xiocd_req_s;
    typedef struct packed {
        logic        done;
        logic        illegal;
        logic        rdValid;
        logic [15:0] rdata;
    } xiocd_rsp_s;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        needReady;
        logic [15:0] addr;
        logic [15:0] wdata;
    } xiocd_ext_s;
    typedef struct packed {
        logic        setPend;
        logic        resetPend;
        logic        timer1Load;
        logic        timer2Load;
        logic        faultMaskLoad;
        logic        faultClear;
        logic [15:0] data;
    } xiocd_act_s;
    typedef struct packed {
        xiocd_rsp_s  rsp;
        xiocd_ext_s  ext;
        xiocd_act_s  act;
        logic [15:0] discreteOut;
        logic        dmaPermit;
    } xiocd_state_s;
endpackage

// file: logic/xio_command_decoder.sv
`timescale 1ns/10ps
`include "xiocd_map.svh"
module xio_command_decoder
    import xiocd_pkg::*;
(
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // Processor side
    input  wire xiocd_pkg::xiocd_req_s req,
    input  wire logic [3:0]         processor_state_field,
    input  wire logic               modeB,
    input  wire logic [15:0]        internalConfig,
    output xiocd_pkg::xiocd_rsp_s   rsp,
    // Internal function sources
    input  wire logic [15:0]        faultReg,
    input  wire logic [15:0]        faultMask,
    input  wire logic [15:0]        intMask,
    input  wire logic [15:0]        pendingIrq,
    input  wire logic [15:0]        statusWord,
    input  wire logic [15:0]        bankSelect,
    input  wire logic [15:0]        timer1Reload,
    input  wire logic [15:0]        timer2Reload,
    input  wire logic [15:0]        failAddress,
    input  wire logic [15:0]        failPage,
    // Internal function controls
    output xiocd_pkg::xiocd_act_s   act,
    output logic [15:0]             discreteOut,
    output logic                    dmaPermit,
    output logic                    illegalFault,
    // External I/O cycle
    output xiocd_pkg::xiocd_ext_s   ext,
    input  wire logic               extDone,
    input  wire logic [15:0]        extRdata
);
    import xiocd_pkg::*;

    xiocd_state_s st;
    xiocd_state_s next_st;
    xiocd_kind_e  kind;
    logic         priv;
    logic         isRead;
    logic [15:0]  intData;
    logic [7:0]   hi;
    logic [15:0]  c;
    logic         dmaPresent;
    logic         mmuPresent;
    logic         bpuPresent;
    logic         conPresent;

    // Optional devices; a command aimed at an absent one must never reach the bus
    assign dmaPresent = internalConfig[`XIOCD_CFG_DMA];
    assign mmuPresent = internalConfig[`XIOCD_CFG_MMU];
    assign bpuPresent = internalConfig[`XIOCD_CFG_BPU];
    assign conPresent = internalConfig[`XIOCD_CFG_CON];

    // Classify the command; every code in the execute_io_instruction space is privileged
    always_comb
    begin
        c      = req.code;
        hi     = c[15:8];
        kind   = XIOCD_ILL;
        priv   = 1'b1;
        isRead = c[15];
        case (c)
            `XIOCD_SMK, `XIOCD_CLIR, `XIOCD_ENBL, `XIOCD_DSBL, `XIOCD_RPI, `XIOCD_SPI,
            `XIOCD_RNS, `XIOCD_WPBSA, `XIOCD_ESUR, `XIOCD_DSUR:
                kind = XIOCD_INT;
            `XIOCD_RSW:
                kind = XIOCD_INT;
            `XIOCD_NOP_OUT, `XIOCD_NOP_IN:
                kind = XIOCD_INT;
            `XIOCD_OD, `XIOCD_WSW, `XIOCD_READ_DISCRETE_OUT_CMD, `XIOCD_RCW:
                kind = XIOCD_EXT;
            `XIOCD_LOAD_TIMER1_RELOAD_CMD, `XIOCD_LOAD_TIMER2_RELOAD_CMD, `XIOCD_ITAR, `XIOCD_ITBR, `XIOCD_SET_FAULT_MASK_CMD, `XIOCD_WPBSB,
            `XIOCD_READ_BANK_SELECT_CMD, `XIOCD_READ_FAULT_MASK_CMD:
                kind = modeB ? XIOCD_INT : XIOCD_ILL;
            `XIOCD_DMAON, `XIOCD_DMAOFF:
                kind = dmaPresent ? XIOCD_INT : XIOCD_ILL;
            `XIOCD_MPEN:
                kind = bpuPresent ? XIOCD_EXT : XIOCD_ILL;
            `XIOCD_CO, `XIOCD_CC, `XIOCD_CI:
                kind = conPresent ? XIOCD_EXT : XIOCD_ILL;
            `XIOCD_RFR, `XIOCD_READ_CLEAR_FAULT_CMD, `XIOCD_READ_FAIL_ADDRESS_CMD, `XIOCD_READ_FAIL_PAGE_CMD, `XIOCD_ICW, `XIOCD_RMK,
            `XIOCD_RPIR:
                kind = XIOCD_INT;
            default:
            begin
                // Whole pages belong to the protect and paging units, which decode the low byte
                if (hi == `XIOCD_HI_BPU_W || hi == `XIOCD_HI_BPU_R)
                    kind = bpuPresent ? XIOCD_EXT : XIOCD_ILL;
                else if (hi == `XIOCD_HI_IPW || hi == `XIOCD_HI_OPW || hi == `XIOCD_HI_IPR
                         || hi == `XIOCD_HI_OPR)
                    kind = mmuPresent ? XIOCD_EXT : XIOCD_ILL;
            end
        endcase
        // Privilege is tested last so that it overrides every other outcome
        if (priv && processor_state_field != 4'h0)
            kind = XIOCD_ILL;
    end

    // Read sources; only used when the command completes internally
    always_comb
    begin
        case (c)
            `XIOCD_RFR, `XIOCD_READ_CLEAR_FAULT_CMD: intData = faultReg;
            `XIOCD_ICW:              intData = internalConfig;
            `XIOCD_READ_FAIL_ADDRESS_CMD:             intData = failAddress;
            `XIOCD_READ_FAIL_PAGE_CMD:             intData = failPage;
            `XIOCD_RMK:              intData = intMask;
            `XIOCD_RPIR:             intData = pendingIrq;
            `XIOCD_READ_FAULT_MASK_CMD:             intData = faultMask;
            `XIOCD_READ_BANK_SELECT_CMD:             intData = bankSelect;
            `XIOCD_RSW:              intData = statusWord;
            `XIOCD_ITAR:             intData = timer1Reload;
            `XIOCD_ITBR:             intData = timer2Reload;
            default:                 intData = 16'h0000;
        endcase
    end

    always_comb
    begin
        next_st     = st;
        next_st.rsp = '0;
        next_st.act = '0;
        if (st.ext.valid)
        begin
            // Bus cycle holds until the far end answers; console relies on it
            if (extDone)
            begin
                next_st.ext.valid   = 1'b0;
                next_st.rsp.done    = 1'b1;
                next_st.rsp.rdValid = st.ext.addr[15];
                // The discrete register lives here; its bus cycle only mirrors it outside
                if (!st.ext.addr[15])
                    next_st.rsp.rdata = 16'h0000;
                else if (st.ext.addr == `XIOCD_READ_DISCRETE_OUT_CMD)
                    next_st.rsp.rdata = st.discreteOut;
                else
                    next_st.rsp.rdata = extRdata;
            end
        end
        else if (req.valid)
        begin
            next_st.act.data = req.wdata;
            case (kind)
                XIOCD_ILL:
                begin
                    // Refused commands still complete, so the processor never waits on them
                    next_st.rsp.done    = 1'b1;
                    next_st.rsp.illegal = 1'b1;
                end
                XIOCD_EXT:
                begin
                    // The command word itself is the bus address
                    next_st.ext.valid     = 1'b1;
                    next_st.ext.addr      = c;
                    next_st.ext.write     = ~isRead;
                    next_st.ext.wdata     = (c == `XIOCD_READ_DISCRETE_OUT_CMD) ? st.discreteOut : req.wdata;
                    next_st.ext.needReady = 1'b1;
                    if (c == `XIOCD_OD)
                        next_st.discreteOut = req.wdata;
                end
                XIOCD_INT:
                begin
                    next_st.rsp.done    = 1'b1;
                    next_st.rsp.rdValid = isRead;
                    next_st.rsp.rdata   = intData;
                    // Strobes last one cycle; DMA permit is a level and stays in state
                    case (c)
                        `XIOCD_SPI:    next_st.act.setPend = 1'b1;
                        `XIOCD_RPI:    next_st.act.resetPend = 1'b1;
                        `XIOCD_READ_CLEAR_FAULT_CMD:   next_st.act.faultClear = 1'b1;
                        `XIOCD_LOAD_TIMER1_RELOAD_CMD:   next_st.act.timer1Load = 1'b1;
                        `XIOCD_LOAD_TIMER2_RELOAD_CMD:   next_st.act.timer2Load = 1'b1;
                        `XIOCD_SET_FAULT_MASK_CMD:   next_st.act.faultMaskLoad = 1'b1;
                        `XIOCD_DMAON:  next_st.dmaPermit = 1'b1;
                        `XIOCD_DMAOFF: next_st.dmaPermit = 1'b0;
                        default:       next_st.act.data = req.wdata;
                    endcase
                end
                default:
                    next_st.rsp.done = 1'b0;
            endcase
        end
    end

    // One state register keeps the reset to a single constant load
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    // Every output comes straight from a flop, so consumers see clean pulses
    assign rsp          = st.rsp;
    assign act          = st.act;
    assign ext          = st.ext;
    assign discreteOut  = st.discreteOut;
    assign dmaPermit    = st.dmaPermit;
    assign illegalFault = st.rsp.illegal;
endmodule

// file: testbench/xiocd_ext_dev.sv
`timescale 1ns/10ps
module xiocd_ext_dev
    import xiocd_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // Cycle from the decoder
    input  wire xiocd_pkg::xiocd_ext_s ext,
    input  wire logic [3:0]            lat,
    output logic                       extDone,
    output logic [15:0]                extRdata
);
    logic [3:0] cnt;
    // Ready only after lat wait cycles, so prompt and slow devices both occur
    assign extDone = ext.valid && cnt == lat;
    // Off the ready cycle the data lines carry a moving pattern, not the last word
    assign extRdata = extDone ? ~ext.addr : {4{cnt}};
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            cnt <= 4'h0;
        else if (ext.valid && !extDone)
            cnt <= cnt + 4'h1;
        else
            cnt <= 4'h0;
    end
endmodule

// file: testbench/xiocd_monitor.sv
`timescale 1ns/10ps
module xiocd_monitor
    import xiocd_pkg::*;
(
    // Clock and reset
    input wire logic                  ref_clk,
    input wire logic                  rst,
    // Observed ports
    input wire xiocd_pkg::xiocd_req_s req,
    input wire logic [3:0]            processor_state_field,
    input wire logic                  modeB,
    input wire logic [15:0]           internalConfig,
    input wire logic [15:0]           faultReg,
    input wire xiocd_pkg::xiocd_rsp_s rsp,
    input wire xiocd_pkg::xiocd_act_s act,
    input wire logic [15:0]           discreteOut,
    input wire logic                  dmaPermit,
    input wire xiocd_pkg::xiocd_ext_s ext,
    input wire logic                  extDone
);
    wire logic go = req.valid && !ext.valid && processor_state_field == 4'h0;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_priv_refused: assert property (req.valid && !ext.valid && processor_state_field != 4'h0 |=> rsp.done && rsp.illegal) else $error("privileged command not refused");
    a_pend_set: assert property (go && req.code == 16'h2005 |=> act.setPend && act.data == $past(req.wdata)) else $error("pending set missing");
    a_fault_clear: assert property (go && req.code == 16'ha00f |=> act.faultClear && rsp.rdata == $past(faultReg)) else $error("fault read and clear wrong");
    a_fault_keep: assert property (go && req.code == 16'h8401 |=> !act.faultClear && rsp.rdata == $past(faultReg)) else $error("fault read cleared");
    a_disc_write: assert property (go && req.code == 16'h2008 |=> ext.valid && discreteOut == $past(req.wdata)) else $error("discrete write wrong");
    a_modea_refuse: assert property (go && !modeB && req.code == 16'h4002 |=> rsp.illegal && !act.timer1Load) else $error("B only code taken in A mode");
    a_dma_on: assert property (go && internalConfig[0] && req.code == 16'h4006 |=> dmaPermit) else $error("dma permit not set");
    a_cfg_internal: assert property (go && req.code == 16'h840c |=> !ext.valid && rsp.rdata == $past(internalConfig)) else $error("config read wrong");
    a_ext_hold: assert property (ext.valid && !extDone |=> ext.valid && $stable(ext.addr)) else $error("external cycle dropped");
    a_ready_end: assert property (ext.valid && extDone |=> rsp.done && !ext.valid ##1 !rsp.done) else $error("external end wrong");
endmodule
bind xio_command_decoder xiocd_monitor mon (.ref_clk, .rst, .req, .processor_state_field, .modeB, .internalConfig,
    .faultReg, .rsp, .act, .discreteOut, .dmaPermit, .ext, .extDone);

// file: testbench/xio_command_decoder_tb_top.sv
`timescale 1ns/10ps
module xio_command_decoder_tb_top;
    import xiocd_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    xiocd_req_s  req = '0;
    logic [3:0]  procState = 4'h0;
    logic        modeB = 1'b1;
    logic [15:0] cfg = 16'h000f;
    logic [3:0]  lat = 4'h0;
    logic [15:0] src [10] = '{16'h5a3c, 16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h6666, 16'h7777,
                              16'h2468, 16'h0013};
    xiocd_rsp_s  rsp, r;
    xiocd_act_s  act, a;
    xiocd_ext_s  ext, e;
    logic [15:0] discreteOut, extRdata;
    logic        dmaPermit, extDone, illegalFault, f;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cyc = 0;
    xio_command_decoder dut (.ref_clk, .rst, .req, .processor_state_field(procState), .modeB, .internalConfig(cfg),
        .rsp, .faultReg(src[0]), .faultMask(src[1]), .intMask(src[2]), .pendingIrq(src[3]), .statusWord(src[4]),
        .bankSelect(src[5]), .timer1Reload(src[6]), .timer2Reload(src[7]), .failAddress(src[8]), .failPage(src[9]),
        .act, .discreteOut, .dmaPermit, .illegalFault, .ext, .extDone, .extRdata);
    xiocd_ext_dev far (.ref_clk, .rst, .ext, .lat, .extDone, .extRdata);
    always #50 ref_clk = ~ref_clk;
    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            n_mismatch++;
            results();
        end
    end
    task results;
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chkf(input logic got, input logic exp);
        chk({15'h0, got}, {15'h0, exp});
    endtask
    task xio(input logic [15:0] code, input logic [15:0] wd);
        @(posedge ref_clk) req <= '{1'b1, code, wd};
        @(posedge ref_clk) req.valid <= 1'b0;
        #1 a = act;
        e = ext;
        // A cycle that never ends is caught by the run's watchdog
        while (rsp.done !== 1'b1)
            @(posedge ref_clk) #1;
        r = rsp;
        f = illegalFault;
    endtask
    task ill(input logic [15:0] code, input logic exp);
        xio(code, 16'h0);
        chkf(r.illegal, exp);
        chkf(f, exp);
    endtask
    task t_basic;
        @(posedge ref_clk) procState <= 4'h3;
        ill(16'h2005, 1'b1);
        @(posedge ref_clk) procState <= 4'h0;
        xio(16'h2005, 16'h0081);
        chk(a.data, 16'h0081);
        chkf(a.setPend, 1'b1);
        xio(16'h2004, 16'h0007);
        chkf(a.resetPend & ~a.setPend, 1'b1);
        xio(16'ha00f, 16'h0);
        chk(r.rdata, 16'h5a3c);
        chkf(a.faultClear, 1'b1);
        xio(16'h8401, 16'h0);
        chkf(a.faultClear, 1'b0);
        chk(r.rdata, 16'h5a3c);
        @(posedge ref_clk) lat <= 4'h5;
        xio(16'h2008, 16'hc3a5);
        chk(discreteOut, 16'hc3a5);
        chk(e.addr, 16'h2008);
        xio(16'ha008, 16'h0);
        chk(r.rdata, 16'hc3a5);
        chkf(e.valid, 1'b1);
        @(posedge ref_clk) lat <= 4'h0;
        xio(16'h840c, 16'h0);
        chkf(e.valid, 1'b0);
        chk(r.rdata, 16'h000f);
        xio(16'h8407, 16'h0);
        chk(r.rdata, 16'h2468);
        xio(16'h8408, 16'h0);
        chk(r.rdata, 16'h0013);
        ill(16'ha00e, 1'b0);
        chk(r.rdata, 16'h4444);
    endtask
    task t_mode;
        @(posedge ref_clk) modeB <= 1'b0;
        ill(16'h400f, 1'b1);
        ill(16'h4002, 1'b1);
        chkf(a.timer1Load, 1'b0);
        ill(16'ha00c, 1'b1);
        ill(16'h2006, 1'b1);
        ill(16'ha006, 1'b1);
        @(posedge ref_clk) modeB <= 1'b1;
        ill(16'h400f, 1'b0);
        chkf(a.timer2Load, 1'b1);
        ill(16'h4002, 1'b0);
        chkf(a.timer1Load, 1'b1);
        ill(16'ha006, 1'b0);
        chk(r.rdata, 16'h1111);
        ill(16'ha00c, 1'b0);
        chk(r.rdata, 16'h5555);
        ill(16'h2006, 1'b0);
        chkf(a.faultMaskLoad, 1'b1);
        ill(16'h4006, 1'b0);
        chkf(dmaPermit, 1'b1);
        ill(16'h4007, 1'b0);
        chkf(dmaPermit, 1'b0);
        @(posedge ref_clk) cfg <= 16'h000e;
        ill(16'h4006, 1'b1);
        chkf(dmaPermit, 1'b0);
        @(posedge ref_clk) cfg <= 16'h000b;
        ill(16'h5012, 1'b1);
        @(posedge ref_clk) cfg <= 16'h000d;
        ill(16'h5177, 1'b1);
        @(posedge ref_clk) cfg <= 16'h0007;
        ill(16'h4000, 1'b1);
        @(posedge ref_clk) cfg <= 16'h000f;
    endtask
    task t_ext;
        logic [15:0] c [7];
        logic [6:0]  wr;
        c = '{16'h5012, 16'hd034, 16'h5177, 16'h5288, 16'hd1a5, 16'hd2c3, 16'h4000};
        // Direction each command must take on the bus: loads and writes go out, reads come in
        wr = 7'b1001101;
        for (int k = 0; k < 7; k++)
        begin
            @(posedge ref_clk) lat <= k[3:0];
            ill(c[k], 1'b0);
            chk(e.addr, c[k]);
            chkf(e.write, wr[k]);
            if (!wr[k])
                chk(r.rdata, ~c[k]);
        end
        ill(16'hc001, 1'b0);
        chkf(|a[21:16] | e.valid, 1'b0);
        ill(16'h4001, 1'b0);
        chkf(|a[21:16] | e.valid, 1'b0);
        chk(discreteOut, 16'hc3a5);
        ill(16'h0500, 1'b1);
        ill(16'hb000, 1'b1);
        ill(16'h6000, 1'b1);
    endtask
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        t_basic();
        t_mode();
        t_ext();
        results();
    end
endmodule
